// ---- hfr_fifo_access.sv ----
// Host register access to transmit and receive FIFO RAM words and pointers
`timescale 1ns/1ps
// Operation
// - Tx read data register returns low 32 bits of the addressed Tx RAM word.
// - Tx read address with select high holds the Tx module pointer read.
// - Rx write ack rises on acceptance and changes only after request changes.
// - Control byte: bits 39-36 unused, 35 start of frame, 34 end of frame.
// - Bits 33-32 give valid bytes of last word: 0 all, 1-3 low 3,2,1.
// - Reading the Rx write address field returns the Rx module write pointer.
// - Rx write address: select low gives RAM location, high a pointer load.
// - Rx write data register holds low 32 bits of the word to write.
// - Rx read ack rises once data fetched; changes only after request changes.
// - Rx read control byte is read-only and shows the fetched word's byte.
// - Rx read address: select low reads RAM, high captures the module pointer.
// - Rx read data register returns low 32 bits of the fetched Rx word.
module hfr_fifo_access #(
    parameter int TX_RAM_DEPTH_BITS = hfr_pkg::DEPTH_BITS_DEF,
    parameter int RX_RAM_DEPTH_BITS = hfr_pkg::DEPTH_BITS_DEF
) (
    input  wire logic                         clock_i,         // 100 MHz clock
    input  wire logic                         rst_n_i,         // Async reset
    input  wire logic [9:0]                   reg_addr_i,      // Reg address
    input  wire logic                         reg_wr_i,        // Reg write
    input  wire logic                         reg_rd_i,        // Reg read
    input  wire logic [31:0]                  reg_wdata_i,     // Write data
    output logic      [31:0]                  reg_rdata_o,     // Read data
    output logic                              tx_ram_rd_en_o,  // Tx RAM read
    output logic [TX_RAM_DEPTH_BITS-1:0]      tx_ram_rd_addr_o, // Tx RAM addr
    input  wire logic [hfr_pkg::WORD_W-1:0]   tx_ram_rd_data_i, // Tx RAM word
    input  wire logic [TX_RAM_DEPTH_BITS:0]   tx_rd_ptr_i,     // Tx module ptr
    output logic                              rx_ram_wr_en_o,  // Rx RAM write
    output logic [RX_RAM_DEPTH_BITS-1:0]      rx_ram_wr_addr_o, // Rx wr addr
    output logic [hfr_pkg::WORD_W-1:0]        rx_ram_wr_data_o, // Rx wr word
    output logic                              rx_ptr_wr_en_o,  // Rx ptr load
    output logic [RX_RAM_DEPTH_BITS:0]        rx_ptr_wr_val_o, // Rx ptr value
    input  wire logic [RX_RAM_DEPTH_BITS:0]   rx_wr_ptr_i,     // Rx write ptr
    output logic                              rx_ram_rd_en_o,  // Rx RAM read
    output logic [RX_RAM_DEPTH_BITS-1:0]      rx_ram_rd_addr_o, // Rx rd addr
    input  wire logic [hfr_pkg::WORD_W-1:0]   rx_ram_rd_data_i, // Rx RAM word
    input  wire logic [RX_RAM_DEPTH_BITS:0]   rx_rd_ptr_i      // Rx read ptr
);

    localparam int TA = TX_RAM_DEPTH_BITS;
    localparam int RA = RX_RAM_DEPTH_BITS;
    localparam int DW = hfr_pkg::DATA_W;

    logic                        tx_req_q;
    logic [TA+1:0]               tx_adx_q;
    logic [hfr_pkg::WORD_W-1:0]  tx_rdat_q;
    logic                        rx_wreq_q;
    logic [RA+1:0]               rx_wadx_q;
    logic [hfr_pkg::CTL_W-1:0]   rx_wctl_q;
    logic [DW-1:0]               rx_wdat_q;
    logic                        rx_rreq_q;
    logic [RA+1:0]               rx_radx_q;
    logic [hfr_pkg::WORD_W-1:0]  rx_rdat_q;
    logic [hfr_pkg::CH_N-1:0]    req;
    logic [hfr_pkg::CH_N-1:0]    start;
    logic [hfr_pkg::CH_N-1:0]    ack;
    logic [hfr_pkg::CH_N-1:0]    issue_q;
    logic [hfr_pkg::CH_N-1:0]    cap_q;
    logic                        tx_rd_en_q;
    logic                        rx_wr_en_q;
    logic                        rx_ptr_en_q;
    logic                        rx_rd_en_q;
    logic [31:0]                 rdata_d;
    logic [31:0]                 rdata_q;
    logic                        tx_sel;
    logic                        rxw_sel;
    logic                        rxr_sel;
    logic                        wr_txc;
    logic                        wr_rxwc;
    logic                        wr_rxwd;
    logic                        wr_rxrc;

    // Select bit sits just above the pointer field in each address field
    assign tx_sel  = tx_adx_q[TA+1];
    assign rxw_sel = rx_wadx_q[RA+1];
    assign rxr_sel = rx_radx_q[RA+1];

    // Register write decode
    assign wr_txc  = reg_wr_i && (reg_addr_i == hfr_pkg::TX_RD_CTRL_OFF);
    assign wr_rxwc = reg_wr_i && (reg_addr_i == hfr_pkg::RX_WR_CTRL_OFF);
    assign wr_rxwd = reg_wr_i && (reg_addr_i == hfr_pkg::RX_WR_DATA_OFF);
    assign wr_rxrc = reg_wr_i && (reg_addr_i == hfr_pkg::RX_RD_CTRL_OFF);

    assign req = {rx_rreq_q, rx_wreq_q, tx_req_q};

    // One handshake engine per channel
    genvar ch;
    generate
        for (ch = 0; ch < hfr_pkg::CH_N; ch++) begin : g_hs
            hfr_handshake u_hs (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .req_i   (req[ch]),
                .done_i  (cap_q[ch]),
                .start_o (start[ch]),
                .ack_o   (ack[ch])
            );
        end
    endgenerate

    // Access pipeline: issue, then RAM answers a cycle later, then capture
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            issue_q <= '0;
            cap_q   <= '0;
        end else begin
            issue_q <= start;
            cap_q   <= issue_q;
        end
    end

    // Strobes to the RAMs and receive module, one cycle each
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_rd_en_q  <= 1'b0;
            rx_wr_en_q  <= 1'b0;
            rx_ptr_en_q <= 1'b0;
            rx_rd_en_q  <= 1'b0;
        end else begin
            tx_rd_en_q  <= start[hfr_pkg::CH_TXR] && !tx_sel;
            rx_wr_en_q  <= start[hfr_pkg::CH_RXW] && !rxw_sel;
            rx_ptr_en_q <= start[hfr_pkg::CH_RXW] && rxw_sel;
            rx_rd_en_q  <= start[hfr_pkg::CH_RXR] && !rxr_sel;
        end
    end

    assign tx_ram_rd_en_o   = tx_rd_en_q;
    assign tx_ram_rd_addr_o = tx_adx_q[TA-1:0];
    assign rx_ram_wr_en_o   = rx_wr_en_q;
    assign rx_ram_wr_addr_o = rx_wadx_q[RA-1:0];
    assign rx_ptr_wr_en_o   = rx_ptr_en_q;
    assign rx_ptr_wr_val_o  = rx_wadx_q[RA:0];
    assign rx_ram_rd_en_o   = rx_rd_en_q;
    assign rx_ram_rd_addr_o = rx_radx_q[RA-1:0];

    // Unused control nibble forced to zero so stale host bits never reach RAM
    assign rx_ram_wr_data_o = {{(hfr_pkg::CTL_W-hfr_pkg::USED_W){1'b0}},
                               rx_wctl_q[hfr_pkg::USED_W-1:0],
                               rx_wdat_q};

    // Transmit read channel: host fields, then capture of word or pointer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_req_q  <= 1'b0;
            tx_adx_q  <= '0;
            tx_rdat_q <= '0;
        end else begin
            if (wr_txc) begin
                tx_req_q <= reg_wdata_i[hfr_pkg::REQ_BIT];
                tx_adx_q <= reg_wdata_i[TA+1:0];
            end
            if (cap_q[hfr_pkg::CH_TXR]) begin
                if (tx_sel) begin
                    tx_adx_q[TA:0] <= tx_rd_ptr_i;
                end else begin
                    tx_rdat_q <= tx_ram_rd_data_i;
                end
            end
        end
    end

    // Receive write channel: request, address, control byte and data
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_wreq_q <= 1'b0;
            rx_wadx_q <= '0;
            rx_wctl_q <= '0;
            rx_wdat_q <= '0;
        end else begin
            if (wr_rxwc) begin
                rx_wreq_q <= reg_wdata_i[hfr_pkg::REQ_BIT];
                rx_wadx_q <= reg_wdata_i[RA+1:0];
                rx_wctl_q <= reg_wdata_i[hfr_pkg::CTL_MSB:hfr_pkg::CTL_LSB];
            end
            if (wr_rxwd) begin
                rx_wdat_q <= reg_wdata_i;
            end
        end
    end

    // Receive read channel; the read word is never host-writable
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_rreq_q <= 1'b0;
            rx_radx_q <= '0;
            rx_rdat_q <= '0;
        end else begin
            if (wr_rxrc) begin
                rx_rreq_q <= reg_wdata_i[hfr_pkg::REQ_BIT];
                rx_radx_q <= reg_wdata_i[RA+1:0];
            end
            if (cap_q[hfr_pkg::CH_RXR]) begin
                if (rxr_sel) begin
                    rx_radx_q[RA:0] <= rx_rd_ptr_i;
                end else begin
                    rx_rdat_q <= rx_ram_rd_data_i;
                end
            end
        end
    end

    // Read mux; anything not placed reads zero, unmapped offsets too
    always_comb begin
        rdata_d = hfr_pkg::REG_RST;
        unique case (reg_addr_i)
            hfr_pkg::TX_RD_CTRL_OFF: begin
                rdata_d[hfr_pkg::REQ_BIT] = tx_req_q;
                rdata_d[hfr_pkg::ACK_BIT] = ack[hfr_pkg::CH_TXR];
                rdata_d[hfr_pkg::CTL_MSB:hfr_pkg::CTL_LSB] =
                    tx_rdat_q[hfr_pkg::WORD_W-1:DW];
                rdata_d[TA+1:0] = tx_adx_q;
            end
            hfr_pkg::TX_RD_DATA_OFF: rdata_d = tx_rdat_q[DW-1:0];
            hfr_pkg::RX_WR_CTRL_OFF: begin
                rdata_d[hfr_pkg::REQ_BIT] = rx_wreq_q;
                rdata_d[hfr_pkg::ACK_BIT] = ack[hfr_pkg::CH_RXW];
                rdata_d[hfr_pkg::CTL_MSB:hfr_pkg::CTL_LSB] = rx_wctl_q;
                rdata_d[RA:0] = rx_wr_ptr_i;
            end
            hfr_pkg::RX_WR_DATA_OFF: rdata_d = rx_wdat_q;
            hfr_pkg::RX_RD_CTRL_OFF: begin
                rdata_d[hfr_pkg::REQ_BIT] = rx_rreq_q;
                rdata_d[hfr_pkg::ACK_BIT] = ack[hfr_pkg::CH_RXR];
                rdata_d[hfr_pkg::CTL_MSB:hfr_pkg::CTL_LSB] =
                    rx_rdat_q[hfr_pkg::WORD_W-1:DW];
                rdata_d[RA+1:0] = rx_radx_q;
            end
            hfr_pkg::RX_RD_DATA_OFF: rdata_d = rx_rdat_q[DW-1:0];
            default: rdata_d = hfr_pkg::REG_RST;
        endcase
    end

    // Read data registered; held between reads so software sees a stable word
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= hfr_pkg::REG_RST;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    tx_word_cap_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(ack[hfr_pkg::CH_TXR]) && !tx_sel
            |-> tx_rdat_q == $past(tx_ram_rd_data_i))
        else $error("tx read word not captured at ack");

    tx_ptr_cap_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(ack[hfr_pkg::CH_TXR]) && tx_sel
            |-> tx_adx_q[TA:0] == $past(tx_rd_ptr_i))
        else $error("tx pointer not captured at ack");

    rx_wr_issue_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        start[hfr_pkg::CH_RXW] && !rxw_sel
            |=> rx_ram_wr_en_o && !rx_ptr_wr_en_o
                ##1 !rx_ram_wr_en_o ##1 ack[hfr_pkg::CH_RXW])
        else $error("rx write strobe or ack timing wrong");

    rx_wr_word_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        rx_ram_wr_en_o |-> rx_ram_wr_data_o[hfr_pkg::WORD_W-1:hfr_pkg::SOF_BIT+1]
            == '0 && rx_ram_wr_data_o[DW-1:0] == rx_wdat_q)
        else $error("rx write word badly formed");

    rx_ptr_view_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == hfr_pkg::RX_WR_CTRL_OFF
            |=> reg_rdata_o[RA:0] == $past(rx_wr_ptr_i))
        else $error("rx write address read is not the live pointer");

    rx_rd_ack_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == hfr_pkg::RX_RD_CTRL_OFF
            |=> reg_rdata_o[hfr_pkg::ACK_BIT] == $past(ack[hfr_pkg::CH_RXR]))
        else $error("rx read ack bit misreported");

    rx_rd_cap_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(ack[hfr_pkg::CH_RXR]) && !rxr_sel
            |-> rx_rdat_q == $past(rx_ram_rd_data_i, 1))
        else $error("rx read word not captured at ack");

    rx_rd_ro_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        reg_wr_i && !cap_q[hfr_pkg::CH_RXR]
            |=> rx_rdat_q == $past(rx_rdat_q))
        else $error("host write changed the rx read word");

    rsvd_zero_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        reg_rd_i && reg_addr_i == hfr_pkg::RX_RD_CTRL_OFF
            |=> reg_rdata_o[hfr_pkg::ACK_BIT-1:hfr_pkg::CTL_MSB+1] == '0)
        else $error("reserved bits read nonzero");

endmodule

// ---- hfr_pkg.sv ----
// Shared constants and types for the host FIFO RAM access block
package hfr_pkg;

    // Register offsets on the MAC register port, address bits [9:0]
    localparam logic [9:0] TX_RD_CTRL_OFF = 10'h068;
    localparam logic [9:0] TX_RD_DATA_OFF = 10'h06c;
    localparam logic [9:0] RX_WR_CTRL_OFF = 10'h070;
    localparam logic [9:0] RX_WR_DATA_OFF = 10'h074;
    localparam logic [9:0] RX_RD_CTRL_OFF = 10'h078;
    localparam logic [9:0] RX_RD_DATA_OFF = 10'h07c;

    // Field layout inside the control registers
    localparam int REQ_BIT  = 31;
    localparam int ACK_BIT  = 30;
    localparam int CTL_LSB  = 16;
    localparam int CTL_MSB  = 23;

    // FIFO word layout: 32 data bits plus a frame control byte
    localparam int DATA_W   = 32;
    localparam int CTL_W    = 8;
    localparam int WORD_W   = 40;
    localparam int USED_W   = 4;   // Low nibble of the control byte
    localparam int SOF_BIT  = 35;
    localparam int EOF_BIT  = 34;
    localparam int BE_MSB   = 33;
    localparam int BE_LSB   = 32;

    // Valid byte codes for the last word of a frame
    localparam logic [1:0] BE_ALL4 = 2'h0;
    localparam logic [1:0] BE_LOW3 = 2'h1;
    localparam logic [1:0] BE_LOW2 = 2'h2;
    localparam logic [1:0] BE_LOW1 = 2'h3;

    // Default RAM depth in address bits
    localparam int DEPTH_BITS_DEF = 12;

    // Handshake channel indices
    localparam int CH_TXR = 0;
    localparam int CH_RXW = 1;
    localparam int CH_RXR = 2;
    localparam int CH_N   = 3;

    // Reset values
    localparam logic [31:0] REG_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_BUSY,
        HS_ACK
    } hfr_hs_state_t;

endpackage

// ---- hfr_handshake.sv ----
// Four-phase request/acknowledge engine for one host RAM access channel
`timescale 1ns/1ps
module hfr_handshake (
    input  wire logic clock_i,   // System clock
    input  wire logic rst_n_i,   // Async reset, active low
    input  wire logic req_i,     // Host request level
    input  wire logic done_i,    // Access finished, one-cycle pulse
    output logic      start_o,   // Issue the access, one-cycle pulse
    output logic      ack_o      // Acknowledge level
);

    hfr_pkg::hfr_hs_state_t state_q;
    logic                   start_q;

    // Sequence: one access per rising request, ack held until request drops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= hfr_pkg::HS_IDLE;
        end else begin
            unique case (state_q)
                hfr_pkg::HS_IDLE: begin
                    if (req_i) state_q <= hfr_pkg::HS_BUSY;
                end
                hfr_pkg::HS_BUSY: begin
                    if (done_i) state_q <= hfr_pkg::HS_ACK;
                end
                hfr_pkg::HS_ACK: begin
                    if (!req_i) state_q <= hfr_pkg::HS_IDLE;
                end
            endcase
        end
    end

    // Start pulse fires only on leaving idle, so a held request never repeats
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= (state_q == hfr_pkg::HS_IDLE) && req_i;
        end
    end

    assign start_o = start_q;
    assign ack_o   = (state_q == hfr_pkg::HS_ACK);

    ack_rise_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(ack_o) |-> req_i && $past(req_i))
        else $error("ack rose without a standing request");

    ack_fall_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(ack_o) |-> !$past(req_i))
        else $error("ack fell while request still high");

    ack_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ack_o && req_i |=> ack_o)
        else $error("ack dropped before request was cleared");

    one_start_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        start_o |=> !start_o [*3])
        else $error("second access issued within one handshake");

endmodule

// ---- hfr_ram_model.sv ----
// Behavioural FIFO RAMs and system module pointers facing the access block
`timescale 1ns/1ps
module hfr_ram_model #(
    parameter int          TA     = 12,
    parameter int          RA     = 12,
    parameter logic [TA:0] TX_PTR = '0,  // Tx module read pointer
    parameter logic [RA:0] RX_PTR = '0   // Rx module read pointer
) (
    input  wire logic          clock_i,     // System clock
    input  wire logic          rst_n_i,     // Async reset, active low
    input  wire logic          tx_en_i,     // Tx RAM read strobe
    input  wire logic [TA-1:0] tx_addr_i,   // Tx RAM read address
    output logic      [39:0]   tx_data_o,   // Tx RAM word
    output logic      [TA:0]   tx_ptr_o,    // Tx module pointer
    input  wire logic          wr_en_i,     // Rx RAM write strobe
    input  wire logic [RA-1:0] wr_addr_i,   // Rx RAM write address
    input  wire logic [39:0]   wr_data_i,   // Rx RAM write word
    input  wire logic          ptr_en_i,    // Rx pointer load strobe
    input  wire logic [RA:0]   ptr_val_i,   // Rx pointer load value
    output logic      [RA:0]   wptr_o,      // Rx module write pointer
    input  wire logic          rd_en_i,     // Rx RAM read strobe
    input  wire logic [RA-1:0] rd_addr_i,   // Rx RAM read address
    output logic      [39:0]   rd_data_o,   // Rx RAM word
    output logic      [RA:0]   rptr_o       // Rx module read pointer
);
    logic [39:0] rx_mem [2**RA];
    logic [39:0] tx_q;
    logic [39:0] rx_q;
    logic        tx_v_q;
    logic        rx_v_q;
    logic [RA:0] wptr_q;

    // Tx content is a pattern of the address, so no preload is needed
    function automatic logic [39:0] tx_word(input logic [TA-1:0] a);
        return {8'(a) ^ 8'h5a, 16'hc0de, 16'(a)};
    endfunction

    // One-cycle read latency; writes keep the full 40-bit word
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_q   <= 40'h0;
            rx_q   <= 40'h0;
            tx_v_q <= 1'b0;
            rx_v_q <= 1'b0;
            wptr_q <= '0;
        end else begin
            tx_v_q <= tx_en_i;
            rx_v_q <= rd_en_i;
            if (tx_en_i) tx_q <= tx_word(tx_addr_i);
            if (rd_en_i) rx_q <= rx_mem[rd_addr_i];
            if (wr_en_i) rx_mem[wr_addr_i] <= wr_data_i;
            if (ptr_en_i) wptr_q <= ptr_val_i;
        end
    end

    // Outside the valid cycle the data is inverted so stale reads show up
    assign tx_data_o = tx_v_q ? tx_q : ~tx_q;
    assign rd_data_o = rx_v_q ? rx_q : ~rx_q;
    assign tx_ptr_o  = TX_PTR;
    assign rptr_o    = RX_PTR;
    assign wptr_o    = wptr_q;
endmodule

// ---- hfr_fifo_access_tb.sv ----
// Register-level testbench for the host FIFO RAM access block
`timescale 1ns/1ps
module hfr_fifo_access_tb;
    localparam int          TA   = 12;
    localparam int          RA   = 12;
    localparam logic [TA:0] TPTR = 13'h0a5a;
    localparam logic [RA:0] RPTR = 13'h1234;
    logic          clock_i;
    logic          rst_n_i;
    logic          wr_s;
    logic          rd_s;
    logic [9:0]    addr;
    logic [31:0]   wdat;
    logic [31:0]   rdat;
    logic [31:0]   rd_v;
    logic          tx_en;
    logic          w_en;
    logic          p_en;
    logic          r_en;
    logic [TA-1:0] tx_a;
    logic [RA-1:0] w_a;
    logic [RA-1:0] r_a;
    logic [39:0]   tx_d;
    logic [39:0]   w_d;
    logic [39:0]   r_d;
    logic [TA:0]   tx_p;
    logic [RA:0]   p_v;
    logic [RA:0]   w_p;
    logic [RA:0]   r_p;
    logic [39:0]   exp;
    logic [7:0]    ctl;
    logic [11:0]   wa [4] = '{12'h000, 12'hfff, 12'h555, 12'haaa};
    logic [9:0]    offs [7] = '{10'h068, 10'h06c, 10'h070, 10'h074,
                                10'h078, 10'h07c, 10'h080};
    int            error_cnt = 0;
    int            cmp_count = 0;
    int            stb_cnt = 0;

    hfr_fifo_access hfr_fifo_access_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdat),
        .reg_rdata_o(rdat), .tx_ram_rd_en_o(tx_en),
        .tx_ram_rd_addr_o(tx_a), .tx_ram_rd_data_i(tx_d),
        .tx_rd_ptr_i(tx_p), .rx_ram_wr_en_o(w_en),
        .rx_ram_wr_addr_o(w_a), .rx_ram_wr_data_o(w_d),
        .rx_ptr_wr_en_o(p_en), .rx_ptr_wr_val_o(p_v),
        .rx_wr_ptr_i(w_p), .rx_ram_rd_en_o(r_en),
        .rx_ram_rd_addr_o(r_a), .rx_ram_rd_data_i(r_d),
        .rx_rd_ptr_i(r_p));

    hfr_ram_model #(.TA(TA), .RA(RA), .TX_PTR(TPTR), .RX_PTR(RPTR))
    hfr_ram_model_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .tx_en_i(tx_en),
        .tx_addr_i(tx_a), .tx_data_o(tx_d), .tx_ptr_o(tx_p),
        .wr_en_i(w_en), .wr_addr_i(w_a), .wr_data_i(w_d),
        .ptr_en_i(p_en), .ptr_val_i(p_v), .wptr_o(w_p),
        .rd_en_i(r_en), .rd_addr_i(r_a), .rd_data_o(r_d), .rptr_o(r_p));

    // Clock at 100 MHz
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Every RAM or pointer access strobe is counted
    always @(posedge clock_i) begin
        stb_cnt += (tx_en === 1'b1) + (w_en === 1'b1) + (p_en === 1'b1)
                 + (r_en === 1'b1);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want,
                         input string what);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, want);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clock_i);
        #1;
        addr = a;
        wdat = d;
        wr_s = 1'b1;
        @(posedge clock_i);
        #1;
        wr_s = 1'b0;
    endtask

    // Read data is registered at the edge that takes the strobe
    task automatic rd(input logic [9:0] a);
        @(posedge clock_i);
        #1;
        addr = a;
        rd_s = 1'b1;
        @(posedge clock_i);
        #1;
        rd_s = 1'b0;
        rd_v = rdat;
    endtask

    // Full four-phase handshake; the request is held past the ack on purpose
    task automatic hs(input logic [9:0] a, input logic [31:0] v);
        int          n0;
        int          k;
        logic [31:0] n_acc;
        n0 = stb_cnt;
        wr(a, v | 32'h8000_0000);
        rd(a);
        check({31'h0, rd_v[30]}, 32'h0, "early ack");
        k = 0;
        while (rd_v[30] !== 1'b1 && k < 16) begin
            rd(a);
            k++;
        end
        check({31'h0, rd_v[30]}, 32'h1, "ack rise");
        repeat (6) @(posedge clock_i);
        // Pointer reads only sample a live pointer, so they strobe nothing
        n_acc = (v[TA+1] && a != 10'h070) ? 32'h0 : 32'h1;
        check(32'(stb_cnt - n0), n_acc, "access count");
        // Read-modify-write, so a captured pointer survives the clear
        wr(a, rd_v & 32'h7fff_ffff);
        k = 0;
        rd(a);
        while (rd_v[30] !== 1'b0 && k < 16) begin
            rd(a);
            k++;
        end
        check({31'h0, rd_v[30]}, 32'h0, "ack fall");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #500000;
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        rst_n_i = 1'b0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        addr = 10'h000;
        wdat = 32'h0;
        repeat (10) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        // Writes to a read-only and an unmapped place are dropped
        wr(10'h06c, 32'hffff_ffff);
        wr(10'h080, 32'hffff_ffff);
        foreach (offs[i]) begin
            rd(offs[i]);
            check(rd_v, 32'h0, "reset value");
        end
        // Rx write then read back, one word per byte-valid code
        for (int i = 0; i < 4; i++) begin
            ctl = {4'ha, 2'(i), 2'(i)};
            wr(10'h074, 32'h1234_5670 + i);
            rd(10'h074);
            check(rd_v, 32'h1234_5670 + i, "write data");
            hs(10'h070, {8'h0, ctl, 4'h0, wa[i]});
            rd(10'h070);
            check(rd_v, {8'h0, ctl, 16'h0}, "write ctrl");
            hs(10'h078, {20'h0, wa[i]});
            rd(10'h07c);
            check(rd_v, 32'h1234_5670 + i, "read data");
            rd(10'h078);
            check(rd_v, {12'h0, ctl[3:0], 4'h0, wa[i]}, "read ctrl");
        end
        // Read-only data, ack bit and control byte ignore host writes
        wr(10'h07c, 32'hffff_ffff);
        wr(10'h078, 32'h40ff_0000);
        rd(10'h07c);
        check(rd_v, 32'h1234_5673, "ro data");
        rd(10'h078);
        check(rd_v, 32'h000f_0000, "ro ctrl");
        // Tx reads at both address ends
        for (int i = 0; i < 2; i++) begin
            exp = {wa[i][7:0] ^ 8'h5a, 16'hc0de, 4'h0, wa[i]};
            hs(10'h068, {20'h0, wa[i]});
            rd(10'h06c);
            check(rd_v, exp[31:0], "tx data");
            rd(10'h068);
            check(rd_v, {8'h0, exp[39:32], 4'h0, wa[i]}, "tx ctrl");
        end
        // Pointer reads and a pointer load
        hs(10'h068, 32'h0000_2000);
        rd(10'h068);
        check({16'h0, rd_v[15:0]}, {18'h0, 1'b1, TPTR}, "tx ptr");
        hs(10'h078, 32'h0000_2000);
        rd(10'h078);
        check({16'h0, rd_v[15:0]}, {18'h0, 1'b1, RPTR}, "rx rptr");
        hs(10'h070, 32'h0000_3abc);
        rd(10'h070);
        check(rd_v, 32'h0000_1abc, "rx wptr");
        wrap_up();
    end
endmodule
